// *** core/pwc_channel.sv ***
module pwc_channel
(
    input  wire logic        CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic        FAULT_INPUT_IN,
    output logic             PRIMARY_OUTPUT_OUT,
    output logic             SECONDARY_OUTPUT_OUT,
    output logic             OVERFLOW_IRQ_OUT
);

    // ==========================================================
    // register state
    logic [7:0]  ctrl_q,  ctrl_d;
    logic [7:0]  en_q,    en_d;
    logic [7:0]  per_lo_q, per_lo_d;
    logic [3:0]  per_hi_q, per_hi_d;
    logic [7:0]  dty_lo_q, dty_lo_d;
    logic [3:0]  dty_hi_q, dty_hi_d;
    logic [7:0]  dt2_lo_q, dt2_lo_d;
    logic [3:0]  dt2_hi_q, dt2_hi_d;
    logic [11:0] per_cm_q, per_cm_d;
    logic [11:0] dty_cm_q, dty_cm_d;
    logic [11:0] dt2_cm_q, dt2_cm_d;
    logic [31:0] rdata_d;
    logic        ready_d;
    logic        slverr_d;

    // counter state
    logic [11:0] cnt_q,     cnt_d;
    logic [11:0] per_act_q, per_act_d;
    logic [11:0] dty_act_q, dty_act_d;
    logic [11:0] dt2_act_q, dt2_act_d;
    logic        en_dly_q;
    logic        pri_d, sec_d, irq_d;

    logic        wr_en;
    logic        rd_en;
    logic        tick;
    logic        ovf;
    logic        fault;
    logic        run;
    pwc_pkg::pwc_pair_s pol;
    pwc_pkg::pwc_pair_s fstate;

    assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN && !PREADY_OUT;
    assign rd_en = PSEL_IN && PENABLE_IN && !PWRITE_IN && !PREADY_OUT;
    assign run   = en_q[pwc_pkg::BIT_MOD_EN];
    assign pol   = ctrl_q[pwc_pkg::POL_HI:pwc_pkg::POL_LO];
    assign fstate = en_q[pwc_pkg::FSTATE_HI:pwc_pkg::FSTATE_LO];

    // fault sense: level bit selects which input level counts as fault
    assign fault = en_q[pwc_pkg::BIT_FLT_EN] &&
                   (ctrl_q[pwc_pkg::BIT_FLT_LEVEL] ? FAULT_INPUT_IN
                                                   : !FAULT_INPUT_IN);

    // overflow when the count reaches the period on a counting tick
    assign ovf = run && en_dly_q && tick && (cnt_q >= per_act_q);

    pwc_prescaler u_presc
    (
        .clk_in   (CLK_IN),
        .rst_in   (RST_IN),
        .run_in   (run),
        .sel_in   (pwc_pkg::pwc_div_e'(ctrl_q[pwc_pkg::CKS_HI:pwc_pkg::CKS_LO])),
        .tick_out (tick)
    );

    // ==========================================================
    // register file: apb slave, one wait state, write at the access edge
    always_comb
    begin
        ctrl_d   = ctrl_q;
        en_d     = en_q;
        per_lo_d = per_lo_q;
        per_hi_d = per_hi_q;
        dty_lo_d = dty_lo_q;
        dty_hi_d = dty_hi_q;
        dt2_lo_d = dt2_lo_q;
        dt2_hi_d = dt2_hi_q;
        per_cm_d = per_cm_q;
        dty_cm_d = dty_cm_q;
        dt2_cm_d = dt2_cm_q;
        rdata_d  = 32'h0000_0000;
        ready_d  = PSEL_IN && PENABLE_IN && !PREADY_OUT;
        slverr_d = 1'b0;
        if (wr_en)
        begin
            unique case (PADDR_IN)
                pwc_pkg::ADDR_CONTROL:
                begin
                    ctrl_d = PWDATA_IN[7:0];
                    // status bits only clear by writing zero, never set by software
                    ctrl_d[pwc_pkg::BIT_IRQ_FLAG] = ctrl_q[pwc_pkg::BIT_IRQ_FLAG] &&
                        PWDATA_IN[pwc_pkg::BIT_IRQ_FLAG];
                    ctrl_d[pwc_pkg::BIT_FLT_STAT] = ctrl_q[pwc_pkg::BIT_FLT_STAT] &&
                        PWDATA_IN[pwc_pkg::BIT_FLT_STAT];
                end
                pwc_pkg::ADDR_ENABLE:    en_d = {1'b0, PWDATA_IN[6:0]};
                pwc_pkg::ADDR_PERIOD_LO:
                begin
                    per_lo_d = PWDATA_IN[7:0];
                    per_cm_d = {per_hi_q, PWDATA_IN[7:0]};
                end
                pwc_pkg::ADDR_PERIOD_HI: per_hi_d = PWDATA_IN[3:0];
                pwc_pkg::ADDR_DUTY_LO:
                begin
                    dty_lo_d = PWDATA_IN[7:0];
                    dty_cm_d = {dty_hi_q, PWDATA_IN[7:0]};
                end
                pwc_pkg::ADDR_DUTY_HI:   dty_hi_d = PWDATA_IN[3:0];
                pwc_pkg::ADDR_DUTY2_LO:
                begin
                    dt2_lo_d = PWDATA_IN[7:0];
                    dt2_cm_d = {dt2_hi_q, PWDATA_IN[7:0]};
                end
                pwc_pkg::ADDR_DUTY2_HI:  dt2_hi_d = PWDATA_IN[3:0];
                default:                 slverr_d = 1'b1;
            endcase
        end
        if (rd_en)
        begin
            // reads are side-effect free so a pending commit is never touched
            unique case (PADDR_IN)
                pwc_pkg::ADDR_CONTROL:   rdata_d = {24'h000000, ctrl_q};
                pwc_pkg::ADDR_ENABLE:    rdata_d = {24'h000000, en_q};
                pwc_pkg::ADDR_PERIOD_LO: rdata_d = {24'h000000, per_lo_q};
                pwc_pkg::ADDR_PERIOD_HI: rdata_d = {28'h0000000, per_hi_q};
                pwc_pkg::ADDR_DUTY_LO:   rdata_d = {24'h000000, dty_lo_q};
                pwc_pkg::ADDR_DUTY_HI:   rdata_d = {28'h0000000, dty_hi_q};
                pwc_pkg::ADDR_DUTY2_LO:  rdata_d = {24'h000000, dt2_lo_q};
                pwc_pkg::ADDR_DUTY2_HI:  rdata_d = {28'h0000000, dt2_hi_q};
                default:                 slverr_d = 1'b1;
            endcase
        end
        // hardware set wins over a same-cycle software clear
        if (ovf)
            ctrl_d[pwc_pkg::BIT_IRQ_FLAG] = 1'b1;
        if (fault && run)
            ctrl_d[pwc_pkg::BIT_FLT_STAT] = 1'b1;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            ctrl_q      <= pwc_pkg::RESET_BYTE;
            en_q        <= pwc_pkg::RESET_BYTE;
            per_lo_q    <= pwc_pkg::RESET_BYTE;
            per_hi_q    <= 4'h0;
            dty_lo_q    <= pwc_pkg::RESET_BYTE;
            dty_hi_q    <= 4'h0;
            dt2_lo_q    <= pwc_pkg::RESET_BYTE;
            dt2_hi_q    <= 4'h0;
            per_cm_q    <= pwc_pkg::RESET_WORD;
            dty_cm_q    <= pwc_pkg::RESET_WORD;
            dt2_cm_q    <= pwc_pkg::RESET_WORD;
            PRDATA_OUT  <= 32'h0000_0000;
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
        end
        else
        begin
            ctrl_q      <= ctrl_d;
            en_q        <= en_d;
            per_lo_q    <= per_lo_d;
            per_hi_q    <= per_hi_d;
            dty_lo_q    <= dty_lo_d;
            dty_hi_q    <= dty_hi_d;
            dt2_lo_q    <= dt2_lo_d;
            dt2_hi_q    <= dt2_hi_d;
            per_cm_q    <= per_cm_d;
            dty_cm_q    <= dty_cm_d;
            dt2_cm_q    <= dt2_cm_d;
            PRDATA_OUT  <= rdata_d;
            PREADY_OUT  <= ready_d;
            PSLVERR_OUT <= slverr_d;
        end
    end

    // ==========================================================
    // period counter and waveform
    always_comb
    begin
        cnt_d     = cnt_q;
        per_act_d = per_act_q;
        dty_act_d = dty_act_q;
        dt2_act_d = dt2_act_q;
        if (!run)
        begin
            cnt_d = 12'h001;
        end
        else if (!en_dly_q)
        begin
            // fresh enable: restart from one with the latest committed values
            cnt_d     = 12'h001;
            per_act_d = per_cm_q;
            dty_act_d = dty_cm_q;
            dt2_act_d = dt2_cm_q;
        end
        else if (ovf)
        begin
            cnt_d     = 12'h001;
            per_act_d = per_cm_q;
            dty_act_d = dty_cm_q;
            dt2_act_d = dt2_cm_q;
        end
        else if (tick)
        begin
            cnt_d = cnt_q + 12'h001;
        end

        // count runs 1..period, so duty d gives d active counting periods
        pri_d = run && en_dly_q && (cnt_q <= dty_act_q) && (dty_act_q != 12'h000);
        if (en_q[pwc_pkg::BIT_MODE_SEL])
            sec_d = run && en_dly_q && (cnt_q <= dt2_act_q) && (dt2_act_q != 12'h000);
        else
            sec_d = run && en_dly_q && !pri_d;

        pri_d = pri_d ^ pol.pri;
        sec_d = sec_d ^ pol.sec;
        if (!en_q[pwc_pkg::BIT_PRI_OEN] || !run)
            pri_d = 1'b0;
        if (!en_q[pwc_pkg::BIT_SEC_OEN] || !run)
            sec_d = 1'b0;
        if (run && (fault || ctrl_q[pwc_pkg::BIT_FLT_STAT]))
        begin
            // outputs hold their fault state while running, until the fault is gone and software clears the status
            pri_d = fstate.pri;
            sec_d = fstate.sec;
        end
        irq_d = ctrl_q[pwc_pkg::BIT_IRQ_EN] && ctrl_q[pwc_pkg::BIT_IRQ_FLAG];
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            cnt_q                <= 12'h001;
            per_act_q            <= pwc_pkg::RESET_WORD;
            dty_act_q            <= pwc_pkg::RESET_WORD;
            dt2_act_q            <= pwc_pkg::RESET_WORD;
            en_dly_q             <= 1'b0;
            PRIMARY_OUTPUT_OUT   <= 1'b0;
            SECONDARY_OUTPUT_OUT <= 1'b0;
            OVERFLOW_IRQ_OUT     <= 1'b0;
        end
        else
        begin
            cnt_q                <= cnt_d;
            per_act_q            <= per_act_d;
            dty_act_q            <= dty_act_d;
            dt2_act_q            <= dt2_act_d;
            en_dly_q             <= run;
            PRIMARY_OUTPUT_OUT   <= pri_d;
            SECONDARY_OUTPUT_OUT <= sec_d;
            OVERFLOW_IRQ_OUT     <= irq_d;
        end
    end

endmodule

// *** core/pwc_pkg.sv ***
package pwc_pkg;

    // ==========================================================
    // register map (byte addresses, one aligned word each)
    localparam logic [7:0] ADDR_CONTROL   = 8'h00;
    localparam logic [7:0] ADDR_PERIOD_LO = 8'h04;
    localparam logic [7:0] ADDR_PERIOD_HI = 8'h08;
    localparam logic [7:0] ADDR_DUTY_LO   = 8'h0c;
    localparam logic [7:0] ADDR_DUTY_HI   = 8'h10;
    localparam logic [7:0] ADDR_ENABLE    = 8'h14;
    localparam logic [7:0] ADDR_DUTY2_LO  = 8'h18;
    localparam logic [7:0] ADDR_DUTY2_HI  = 8'h1c;

    // ==========================================================
    // control register fields
    localparam int BIT_IRQ_EN    = 7;
    localparam int BIT_IRQ_FLAG  = 6;
    localparam int BIT_FLT_STAT  = 5;
    localparam int BIT_FLT_LEVEL = 4;
    localparam int POL_HI        = 3;
    localparam int POL_LO        = 2;
    localparam int CKS_HI        = 1;
    localparam int CKS_LO        = 0;

    // enable register fields
    localparam int BIT_MOD_EN    = 0;
    localparam int BIT_PRI_OEN   = 1;
    localparam int BIT_SEC_OEN   = 2;
    localparam int BIT_MODE_SEL  = 3;
    localparam int BIT_FLT_EN    = 4;
    localparam int FSTATE_HI     = 6;
    localparam int FSTATE_LO     = 5;

    localparam int NIBBLE_HI     = 3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [11:0] RESET_WORD = 12'h000;

    // ==========================================================
    // prescaler selections and their division ratios
    typedef enum logic [1:0] {
        PWC_DIV1   = 2'h0,
        PWC_DIV8   = 2'h1,
        PWC_DIV32  = 2'h2,
        PWC_DIV128 = 2'h3
    } pwc_div_e;

    localparam logic [6:0] DIV8_TC   = 7'h07;
    localparam logic [6:0] DIV32_TC  = 7'h1f;
    localparam logic [6:0] DIV128_TC = 7'h7f;

    // polarity and fault state pair: [1] primary, [0] secondary
    typedef struct packed {
        logic pri;
        logic sec;
    } pwc_pair_s;

endpackage

// *** core/pwc_prescaler.sv ***
module pwc_prescaler
(
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    input  wire logic                run_in,
    input  wire pwc_pkg::pwc_div_e   sel_in,
    output logic                     tick_out
);

    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic [6:0] tc;
    logic       tick_d;

    // ==========================================================
    // divider: one-cycle tick every 1, 8, 32 or 128 clocks
    always_comb
    begin
        unique case (sel_in)
            pwc_pkg::PWC_DIV1:   tc = 7'h00;
            pwc_pkg::PWC_DIV8:   tc = pwc_pkg::DIV8_TC;
            pwc_pkg::PWC_DIV32:  tc = pwc_pkg::DIV32_TC;
            pwc_pkg::PWC_DIV128: tc = pwc_pkg::DIV128_TC;
        endcase
        cnt_d  = 7'h00;
        tick_d = 1'b0;
        if (run_in)
        begin
            if (cnt_q >= tc)
                tick_d = 1'b1;
            else
                cnt_d = cnt_q + 7'h01;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cnt_q    <= 7'h00;
            tick_out <= 1'b0;
        end
        else
        begin
            cnt_q    <= cnt_d;
            tick_out <= tick_d;
        end
    end

endmodule

// *** testbench/pwc_channel_sva.sv ***
module pwc_channel_chk
(
    input wire logic        CLK_IN,
    input wire logic        RST_IN,
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic [7:0]  PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        PREADY_OUT,
    input wire logic        PSLVERR_OUT,
    input wire logic        FAULT_INPUT_IN,
    input wire logic        PRIMARY_OUTPUT_OUT,
    input wire logic        SECONDARY_OUTPUT_OUT,
    input wire logic        OVERFLOW_IRQ_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    // ==========================================================
    // bus
    sequence s_done;
        PSEL_IN && PENABLE_IN && PREADY_OUT;
    endsequence
    sequence s_read;
        s_done ##0 !PWRITE_IN;
    endsequence
    sequence s_wr_at(logic [7:0] a);
        s_done ##0 (PWRITE_IN && PADDR_IN == a);
    endsequence
    property p_ready_one;
        PREADY_OUT |=> !PREADY_OUT;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready longer than one cycle");
    property p_ready_wait;
        $rose(PSEL_IN && PENABLE_IN) |=> PREADY_OUT;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready not one cycle after access");
    property p_idle_quiet;
        !PREADY_OUT |-> (PRDATA_OUT == 32'h0 && !PSLVERR_OUT);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("read data or error outside ready");
    property p_unmapped;
        s_done ##0 (PADDR_IN > 8'h1c || PADDR_IN[1:0] != 2'h0) |-> PSLVERR_OUT;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
    property p_mapped;
        s_done ##0 (PADDR_IN <= 8'h1c && PADDR_IN[1:0] == 2'h0) |-> !PSLVERR_OUT;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access flagged");
    property p_hi_zero;
        s_read ##0 (PADDR_IN == pwc_pkg::ADDR_PERIOD_HI || PADDR_IN == pwc_pkg::ADDR_DUTY_HI)
            |-> PRDATA_OUT[31:4] == 28'h0;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("high nibble register upper bits");
    // ==========================================================
    // outputs
    property p_irq_mask;
        s_wr_at(pwc_pkg::ADDR_CONTROL) ##0 !PWDATA_IN[7] |=> ##1 !OVERFLOW_IRQ_OUT [*2];
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq while disabled");
    property p_off;
        s_wr_at(pwc_pkg::ADDR_ENABLE) ##0 !PWDATA_IN[0]
            |=> ##1 (!PRIMARY_OUTPUT_OUT && !SECONDARY_OUTPUT_OUT) [*2];
    endproperty
    a_off: assert property (p_off) else $error("outputs alive after disable");
endmodule

bind pwc_channel pwc_channel_chk u_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .FAULT_INPUT_IN(FAULT_INPUT_IN),
    .PRIMARY_OUTPUT_OUT(PRIMARY_OUTPUT_OUT), .SECONDARY_OUTPUT_OUT(SECONDARY_OUTPUT_OUT),
    .OVERFLOW_IRQ_OUT(OVERFLOW_IRQ_OUT));

// *** testbench/pwc_fault_drv.sv ***
module pwc_fault_drv
(
    input  wire logic level_in,
    input  wire logic active_in,
    output logic      fault_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // fault pin
    // idle rests at the non-fault level so the pin never floats into a fault
    assign fault_out = active_in ? level_in : !level_in;
endmodule

// *** testbench/pwm_channel_ctrl_period_duty_tb.sv ***
module pwm_channel_ctrl_period_duty_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 20000;
    logic        clk     = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        pen     = 1'b0;
    logic        pwr     = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic        flt_lvl = 1'b1;
    logic        flt_act = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, pri, sec, irq, fault;
    int          errors  = 0;
    int          n_tests = 0;
    int          cyc     = 0;

    always #5 clk = ~clk;

    pwc_fault_drv FLT (.level_in(flt_lvl), .active_in(flt_act), .fault_out(fault));
    pwc_channel DUT (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .FAULT_INPUT_IN(fault),
        .PRIMARY_OUTPUT_OUT(pri), .SECONDARY_OUTPUT_OUT(sec), .OVERFLOW_IRQ_OUT(irq));

    // ==========================================================
    // reporting
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            errors++;
            conclude();
        end
    end

    // ==========================================================
    // bus cycles
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, a, d, q, e);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp,
                      input logic ee, input logic [31:0] m = 32'hffffffff);
        logic [31:0] q;
        logic        e;
        xfer(1'b0, a, 32'h0, q, e);
        chk(nm, exp, q & m);
        chk({nm, " error"}, {31'h0, ee}, {31'h0, e});
    endtask

    // settle one window, then count active samples over whole periods
    task automatic wave(input string nm, input int n, input int ep, input int es);
        int p = 0;
        int s = 0;
        repeat (n) @(posedge clk);
        repeat (n)
        begin
            @(posedge clk);
            p += (pri === 1'b1);
            s += (sec === 1'b1);
        end
        chk({nm, " primary"}, 32'(ep), 32'(p));
        chk({nm, " secondary"}, 32'(es), 32'(s));
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        int d;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 32; a += 4)
            rd("reset value", 8'(a), 32'h0, 1'b0);
        rd("unmapped", 8'h40, 32'h0, 1'b1);
        wr(pwc_pkg::ADDR_PERIOD_HI, 32'hff);
        wr(pwc_pkg::ADDR_PERIOD_LO, 32'h0a);
        rd("period high", pwc_pkg::ADDR_PERIOD_HI, 32'h0f, 1'b0);
        rd("period low", pwc_pkg::ADDR_PERIOD_LO, 32'h0a, 1'b0);
        wr(pwc_pkg::ADDR_PERIOD_HI, 32'hf0);
        rd("period high", pwc_pkg::ADDR_PERIOD_HI, 32'h00, 1'b0);
        wr(pwc_pkg::ADDR_PERIOD_LO, 32'h0a);
        wr(pwc_pkg::ADDR_DUTY_HI, 32'hf0);
        wr(pwc_pkg::ADDR_DUTY_LO, 32'h04);
        rd("duty high", pwc_pkg::ADDR_DUTY_HI, 32'h00, 1'b0);
        wr(pwc_pkg::ADDR_ENABLE, 32'h07);
        wave("complementary", 20, 8, 12);
        wr(pwc_pkg::ADDR_PERIOD_HI, 32'h01);
        wave("high only", 20, 8, 12);
        wr(pwc_pkg::ADDR_PERIOD_HI, 32'h00);
        for (int k = 0; k < 4; k++)
        begin
            wr(pwc_pkg::ADDR_CONTROL, 32'(k << 2));
            wave("polarity", 20, k[1] ? 12 : 8, k[0] ? 8 : 12);
        end
        for (int k = 0; k < 4; k++)
        begin
            d = (k == 0) ? 1 : (1 << (2 * k + 1));
            wr(pwc_pkg::ADDR_CONTROL, 32'(k));
            wave("prescale", 20 * d, 8 * d, 12 * d);
        end
        wr(pwc_pkg::ADDR_CONTROL, 32'h00);
        wr(pwc_pkg::ADDR_DUTY2_HI, 32'h00);
        wr(pwc_pkg::ADDR_DUTY2_LO, 32'h02);
        wr(pwc_pkg::ADDR_ENABLE, 32'h0f);
        wave("independent", 20, 8, 4);
        rd("flag set", pwc_pkg::ADDR_CONTROL, 32'h40, 1'b0);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(pwc_pkg::ADDR_ENABLE, 32'h00);
        wave("disabled", 20, 0, 0);
        wr(pwc_pkg::ADDR_CONTROL, 32'hc0);
        repeat (2) @(posedge clk);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(pwc_pkg::ADDR_CONTROL, 32'h80);
        rd("flag cleared", pwc_pkg::ADDR_CONTROL, 32'h80, 1'b0);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(pwc_pkg::ADDR_CONTROL, 32'h10);
        wr(pwc_pkg::ADDR_ENABLE, 32'h17);
        flt_act <= 1'b1;
        wave("fault high", 20, 0, 0);
        rd("fault status", pwc_pkg::ADDR_CONTROL, 32'h30, 1'b0, 32'h30);
        flt_act <= 1'b0;
        wr(pwc_pkg::ADDR_CONTROL, 32'h10);
        wave("fault released", 20, 8, 12);
        // new duty and period are committed mid-period and take over at the next overflow
        wr(pwc_pkg::ADDR_DUTY_LO, 32'h06);
        wr(pwc_pkg::ADDR_PERIOD_HI, 32'h00);
        rd("pending read", pwc_pkg::ADDR_PERIOD_LO, 32'h0a, 1'b0);
        wr(pwc_pkg::ADDR_PERIOD_LO, 32'h0c);
        wave("new period", 24, 12, 12);
        wr(pwc_pkg::ADDR_ENABLE, 32'h13);
        wave("secondary off", 24, 12, 0);
        wr(pwc_pkg::ADDR_ENABLE, 32'h07);
        wr(pwc_pkg::ADDR_CONTROL, 32'h00);
        flt_lvl <= 1'b0;
        // fault state primary high, secondary low: shows the field order on the pins
        wr(pwc_pkg::ADDR_ENABLE, 32'h57);
        flt_act <= 1'b1;
        wave("fault low", 20, 20, 0);
        rd("fault status", pwc_pkg::ADDR_CONTROL, 32'h20, 1'b0, 32'h20);
        conclude();
    end
endmodule
